//--- include/trap_filter_pkg.sv
// Constants, register map and types for the receive word trap filter
package trap_filter_pkg;

  // ==========================================================
  // Register byte offsets
  localparam logic [7:0] OFF_CTRL       = 8'h00;
  localparam logic [7:0] OFF_LABEL      = 8'h04;
  localparam logic [7:0] OFF_PATTERN    = 8'h08;
  localparam logic [7:0] OFF_CARE       = 8'h0c;
  localparam logic [7:0] OFF_TRIG       = 8'h10;
  localparam logic [7:0] OFF_TRIG_DATA  = 8'h14;
  localparam logic [7:0] OFF_STATUS     = 8'h18;
  localparam logic [7:0] OFF_VIEW_INDEX = 8'h1c;
  localparam logic [7:0] OFF_VIEW_WORD  = 8'h20;
  localparam logic [7:0] OFF_SCROLL     = 8'h24;

  // ==========================================================
  // Control, scroll and status bit positions
  localparam int CTRL_TRAP       = 0;
  localparam int CTRL_DATA_ONLY  = 1;
  localparam int CTRL_FILTER     = 2;
  localparam int CTRL_AUTO       = 3;
  localparam int CTRL_LABEL_CARE = 4;
  localparam int CTRL_SDI_CARE   = 5;
  localparam int CTRL_DATA_CARE  = 6;
  localparam int CTRL_TRIG_CARE  = 7;
  localparam int SCROLL_UP       = 0;
  localparam int SCROLL_DOWN     = 1;
  localparam int STAT_ARMED      = 9;
  localparam int STAT_FULL       = 10;

  // ==========================================================
  // Received word layout, reset values and capture depths
  localparam int LABEL_LSB = 0;
  localparam int LABEL_W   = 8;
  localparam int SDI_LSB   = 8;
  localparam int DATA_LSB  = 10;
  localparam int DATA_W    = 19;
  localparam int SSM_LSB   = 29;
  localparam int CARE_LSB  = 8;
  localparam int CARE_W    = 24;
  localparam logic [23:0] CARE_RESET = 24'h000003;
  localparam int GENERAL_DEPTH   = 255;
  localparam int DATA_ONLY_DEPTH = 511;

  // ==========================================================
  // Timing and bus answers
  localparam int CLK_MHZ       = 200;
  localparam int AUTO_STEP_US  = 1000000;
  localparam int AUTO_STEP_CYC = AUTO_STEP_US * CLK_MHZ;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    st_idle, st_armed, st_capture, st_full
  } capture_state_type;

endpackage : trap_filter_pkg

//--- src/serial_word_trap_filter.sv
// Receive word trap memory with filter, match, trigger and readout
// Operation
// - General trap keeps first 255 words in order
// - Data-only capture stores one label 511 times
// - Capture continues while entries are read back
// - Filter keeps matching label and optional SDI
// - Data compare uses 24-bit care mask
// - Mask 7FFFFF compares data, skips parity
// - Default mask compares SDI bits only
// - Mask 600003 compares SSM and SDI only
// - Pattern set outside filter mode: store only masked matches
// - Trap off clears memory, resumes normal reception
// - Readout as octal label, SDI, hex data, SSM
// - Auto readout steps once per second
// - General trap and filter entries keep complete received word
// - Data-only entries carry no label information
// - Armed trigger starts capture on next word
//
// Our own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
module serial_word_trap_filter
  import trap_filter_pkg::*;
#(
  parameter int DEPTH      = DATA_ONLY_DEPTH,
  parameter int STEP_CYCLES = AUTO_STEP_CYC
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  awaddr,
  input  wire logic [2:0]  awprot,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [7:0]  araddr,
  input  wire logic [2:0]  arprot,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic [31:0] rx_word,
  input  wire logic        rx_valid,
  output logic [31:0]      normal_word,
  output logic             normal_valid,
  output logic [11:0]      disp_label_oct,
  output logic [1:0]       disp_sdi,
  output logic [23:0]      disp_data,
  output logic [1:0]       disp_ssm
);

  // ==========================================================
  // Configuration registers
  logic [7:0]  ctrl;
  logic [7:0]  trap_label;
  logic [1:0]  trap_sdi;
  logic [23:0] pattern;
  logic [23:0] care_mask;
  logic [7:0]  start_condition_label;
  logic [23:0] trig_data;

  // ==========================================================
  // Capture state and memory
  logic [31:0]       mem [0:DEPTH-1];
  logic [8:0]        count;
  logic [8:0]        view_index;
  logic              scroll_dir;
  logic [31:0]       tick_count;
  capture_state_type state;
  logic              aw_held;
  logic              w_held;
  logic [7:0]        aw_addr_q;

  // Field split of the incoming word
  wire [7:0]  rx_label = rx_word[LABEL_LSB +: LABEL_W];
  wire [1:0]  rx_sdi   = rx_word[SDI_LSB +: 2];
  wire [23:0] rx_cared = rx_word[CARE_LSB +: CARE_W];

  // Match terms; mask bit 0 lines up with word bit 8
  wire label_hit = rx_label == trap_label;
  wire sdi_hit   = rx_sdi == trap_sdi;
  wire data_hit  = ((rx_cared ^ pattern) & care_mask) == '0;
  wire trig_hit  = (rx_label == start_condition_label) &&
                   (((rx_cared ^ trig_data) & care_mask) == '0);

  // Mode selection
  wire active      = ctrl[CTRL_TRAP] | ctrl[CTRL_FILTER];
  wire filter_mode = ctrl[CTRL_FILTER];
  wire data_only   = ctrl[CTRL_DATA_ONLY] & ~filter_mode;
  // Data-only and filter always select by label
  wire label_need  = filter_mode | data_only | ctrl[CTRL_LABEL_CARE];
  wire sdi_need    = ctrl[CTRL_SDI_CARE];
  wire data_need   = ctrl[CTRL_DATA_CARE] & ~filter_mode;
  wire keep        = (~label_need | label_hit) &
                     (~sdi_need | sdi_hit) &
                     (~data_need | data_hit);
  wire [8:0] capacity = data_only ? 9'(DATA_ONLY_DEPTH)
                                  : 9'(GENERAL_DEPTH);
  wire store = rx_valid && (state == st_capture) && active && keep;
  wire [8:0] next_count = count + 9'h001;
  // Label bits are dropped in data-only entries
  wire [31:0] store_word = data_only ?
    {rx_word[31:LABEL_W], 8'h00} : rx_word;

  // ==========================================================
  // Capture sequencer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= st_idle;
      count <= '0;
    end else begin
      case (state)
        st_idle: begin
          count <= '0;
          if (active)
            state <= ctrl[CTRL_TRIG_CARE] ? st_armed : st_capture;
        end
        st_armed: begin
          if (!active)
            state <= st_idle;
          else if (rx_valid && trig_hit)
            state <= st_capture;
        end
        st_capture: begin
          if (!active) begin
            state <= st_idle;
            count <= '0;
          end else if (store) begin
            count <= next_count;
            if (next_count >= capacity)
              state <= st_full;
          end
        end
        st_full: begin
          if (!active) begin
            state <= st_idle;
            count <= '0;
          end
        end
        default: state <= st_idle;
      endcase
    end
  end

  // Memory holds whole words; no reset so it maps to RAM
  always_ff @(posedge aclk) begin
    if (store)
      mem[count] <= store_word;
  end

  // Words pass straight on while no trap or filter runs
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      normal_valid <= 1'b0;
      normal_word  <= '0;
    end else begin
      normal_valid <= rx_valid & ~active;
      if (rx_valid)
        normal_word <= rx_word;
    end
  end

  // ==========================================================
  // Bus decode
  wire wr_fire   = aw_held & w_held & ~bvalid;
  wire hit_ctrl  = aw_addr_q == OFF_CTRL;
  wire hit_label = aw_addr_q == OFF_LABEL;
  wire hit_pat   = aw_addr_q == OFF_PATTERN;
  wire hit_care  = aw_addr_q == OFF_CARE;
  wire hit_trig  = aw_addr_q == OFF_TRIG;
  wire hit_tdata = aw_addr_q == OFF_TRIG_DATA;
  wire hit_index = aw_addr_q == OFF_VIEW_INDEX;
  wire hit_scrl  = aw_addr_q == OFF_SCROLL;
  wire wr_known  = hit_ctrl | hit_label | hit_pat | hit_care |
                   hit_trig | hit_tdata | hit_index | hit_scrl;

  // Held write data; declared ahead of the lane decode that reads it
  logic [31:0] wdata_q;
  logic [3:0]  wstrb_q;

  // Byte lanes the master enabled take the new data
  wire [31:0] lane_mask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}},
                           {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};

  function automatic logic [31:0] merge(input logic [31:0] old_val,
                                        input logic [31:0] new_val,
                                        input logic [31:0] m);
    merge = (old_val & ~m) | (new_val & m);
  endfunction : merge

  // ==========================================================
  // Write channels; address and data accepted in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held   <= 1'b0;
      awready   <= 1'b0;
      aw_addr_q <= '0;
    end else if (awvalid && awready) begin
      aw_held   <= 1'b1;
      awready   <= 1'b0;
      aw_addr_q <= awaddr;
    end else if (bvalid && bready) begin
      aw_held <= 1'b0;
      awready <= 1'b1;
    end else if (!aw_held && !bvalid) begin
      awready <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held  <= 1'b0;
      wready  <= 1'b0;
      wdata_q <= '0;
      wstrb_q <= '0;
    end else if (wvalid && wready) begin
      w_held  <= 1'b1;
      wready  <= 1'b0;
      wdata_q <= wdata;
      wstrb_q <= wstrb;
    end else if (bvalid && bready) begin
      w_held <= 1'b0;
      wready <= 1'b1;
    end else if (!w_held && !bvalid) begin
      wready <= 1'b1;
    end
  end

  // Response follows both halves; unknown offsets answer SLVERR
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      bresp  <= wr_known ? RESP_OKAY : RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration register writes
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl                  <= '0;
      trap_label            <= '0;
      trap_sdi              <= '0;
      pattern               <= '0;
      care_mask             <= CARE_RESET;
      start_condition_label <= '0;
      trig_data             <= '0;
    end else if (wr_fire) begin
      if (hit_ctrl)
        ctrl <= 8'(merge({24'h0, ctrl}, wdata_q, lane_mask));
      if (hit_label)
        {trap_sdi, trap_label} <= 10'(merge({22'h0, trap_sdi,
          trap_label}, wdata_q, lane_mask));
      if (hit_pat)
        pattern <= 24'(merge({8'h0, pattern}, wdata_q, lane_mask));
      if (hit_care)
        care_mask <= 24'(merge({8'h0, care_mask}, wdata_q, lane_mask));
      if (hit_trig)
        start_condition_label <= 8'(merge({24'h0,
          start_condition_label}, wdata_q, lane_mask));
      if (hit_tdata)
        trig_data <= 24'(merge({8'h0, trig_data}, wdata_q, lane_mask));
    end
  end

  // ==========================================================
  // Readout stepping; reading never touches the capture path
  wire tick = ctrl[CTRL_AUTO] && (tick_count == 32'(STEP_CYCLES - 1));
  wire scroll_up   = wr_fire && hit_scrl && wdata_q[SCROLL_UP];
  wire scroll_down = wr_fire && hit_scrl && wdata_q[SCROLL_DOWN];
  wire [8:0] last_index = (count == '0) ? 9'h000 : count - 9'h001;
  wire [8:0] index_up   = (view_index >= last_index) ? 9'h000
                                                    : view_index + 9'h001;
  wire [8:0] index_down = (view_index == '0) ? last_index
                                             : view_index - 9'h001;

  // One-second divider for automatic readout
  always_ff @(posedge aclk) begin
    if (!aresetn || !ctrl[CTRL_AUTO] || tick)
      tick_count <= '0;
    else
      tick_count <= tick_count + 32'h1;
  end

  // Latest scroll request sets the auto direction
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      view_index <= '0;
      scroll_dir <= 1'b1;
    end else if (!active) begin
      view_index <= '0;
    end else if (wr_fire && hit_index) begin
      view_index <= wdata_q[8:0];
    end else if (scroll_up) begin
      view_index <= index_up;
      scroll_dir <= 1'b1;
    end else if (scroll_down) begin
      view_index <= index_down;
      scroll_dir <= 1'b0;
    end else if (tick) begin
      view_index <= scroll_dir ? index_up : index_down;
    end
  end

  // Selected entry; data-only entries show the selected label
  wire        view_ok   = view_index < count;
  wire [31:0] view_raw  = view_ok ? mem[view_index] : '0;
  wire [31:0] view_word = (view_ok && data_only) ?
    {view_raw[31:LABEL_W], trap_label} : view_raw;
  wire [7:0]  v_label   = view_word[LABEL_LSB +: LABEL_W];

  // Display digits: octal label, binary SDI, hex data, binary SSM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      disp_label_oct <= '0;
      disp_sdi       <= '0;
      disp_data      <= '0;
      disp_ssm       <= '0;
    end else begin
      disp_label_oct <= {2'h0, v_label[7:6], 1'b0, v_label[5:3],
                         1'b0, v_label[2:0]};
      disp_sdi       <= view_word[SDI_LSB +: 2];
      disp_data      <= {5'h00, view_word[DATA_LSB +: DATA_W]};
      disp_ssm       <= view_word[SSM_LSB +: 2];
    end
  end

  // ==========================================================
  // Read channel
  wire [31:0] status = {21'h0, state == st_full, state == st_armed,
                        count};
  wire [31:0] rd_mux =
    (araddr == OFF_CTRL)       ? {24'h0, ctrl} :
    (araddr == OFF_LABEL)      ? {22'h0, trap_sdi, trap_label} :
    (araddr == OFF_PATTERN)    ? {8'h0, pattern} :
    (araddr == OFF_CARE)       ? {8'h0, care_mask} :
    (araddr == OFF_TRIG)       ? {24'h0, start_condition_label} :
    (araddr == OFF_TRIG_DATA)  ? {8'h0, trig_data} :
    (araddr == OFF_STATUS)     ? status :
    (araddr == OFF_VIEW_INDEX) ? {23'h0, view_index} :
    (araddr == OFF_VIEW_WORD)  ? view_word : '0;
  wire rd_known = (araddr <= OFF_VIEW_WORD) && (araddr[1:0] == 2'h0);

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b0;
      rvalid  <= 1'b0;
      rdata   <= '0;
      rresp   <= RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid  <= 1'b1;
      rdata   <= rd_mux;
      rresp   <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid  <= 1'b0;
      arready <= 1'b1;
    end else if (!rvalid) begin
      arready <= 1'b1;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence trig_seen;
    state == st_armed && active && rx_valid && trig_hit;
  endsequence

  a_store_advance: assert property (
    store |=> count == $past(count) + 9'h001)
    else $error("stored word did not advance count");
  a_data_only_full: assert property (
    (data_only && store && count == 9'(DATA_ONLY_DEPTH - 1))
      |=> state == st_full && count == 9'(DATA_ONLY_DEPTH))
    else $error("data-only capture did not stop at full depth");
  a_read_no_stall: assert property (
    (store && arvalid && arready) |=> count != $past(count))
    else $error("readout stalled capture");
  a_filter_discard: assert property (
    (filter_mode && active && state == st_capture && rx_valid &&
     !label_hit) |=> count == $past(count))
    else $error("filter kept a word with wrong label");
  a_care_default: assert property (
    $rose(aresetn) |-> care_mask == CARE_RESET)
    else $error("care mask reset value wrong");
  a_mismatch_drop: assert property (
    (data_need && active && state == st_capture && rx_valid &&
     !data_hit) |=> count == $past(count))
    else $error("non-matching data word stored");
  a_trap_off_clear: assert property (
    $fell(active) |=> count == '0 && state == st_idle)
    else $error("trap off did not clear memory");
  a_trigger_start: assert property (
    trig_seen |=> state == st_capture && count == '0)
    else $error("trigger did not start capture afresh");
  a_full_hold: assert property (
    (state == st_full && active) |=> count == $past(count) &&
      state == st_full)
    else $error("full memory changed");

endmodule : serial_word_trap_filter

//--- testbench/rx_word_source.sv
// Receive link partner: sends queued words, never idles on a stale word
`timescale 1ns/1ps
module rx_word_source (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        slow,
  output logic [31:0]      rx_word,
  output logic             rx_valid
);
  logic [31:0] q[$];
  int          gap = 0;

  // ==========================================================
  // Sender
  // Idle cycles toggle the word so a stale value is never mistaken for data
  always @(posedge aclk) begin
    if (!aresetn) begin
      rx_valid <= 1'b0;
      rx_word  <= 32'h0;
      gap      <= 0;
    end else if (gap != 0 || q.size() == 0) begin
      rx_valid <= 1'b0;
      rx_word  <= ~rx_word;
      if (gap != 0) gap <= gap - 1;
    end else begin
      rx_word  <= q.pop_front();
      rx_valid <= 1'b1;
      gap      <= slow ? int'($urandom_range(2)) : 0; // Slow transmitter
    end
  end
endmodule : rx_word_source

//--- testbench/serial_word_trap_filter_tb.sv
// Self-checking bench for the receive word trap filter
`timescale 1ns/1ps
module serial_word_trap_filter_tb;
  import trap_filter_pkg::*;
  localparam int STEP = 20;
  logic aclk = 0, aresetn = 0, slow = 0;
  logic [7:0] awaddr = 0, araddr = 0;
  logic [2:0] awprot = 0, arprot = 0;
  logic [3:0] wstrb = 4'hf;
  logic [31:0] wdata = 0, rdata, rx_word, normal_word, last_norm;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic awready, wready, bvalid, arready, rvalid, rx_valid, normal_valid;
  logic [1:0] bresp, rresp, resp, disp_sdi, disp_ssm;
  logic [11:0] disp_label_oct;
  logic [23:0] disp_data, m_pat, m_care;
  logic [7:0] m_lab;
  logic m_lc, m_sc, m_dc;
  logic [31:0] exp_q[$];
  int err_count = 0, n_checks = 0, cyc = 0, n_norm = 0;

  serial_word_trap_filter #(.DEPTH(DATA_ONLY_DEPTH), .STEP_CYCLES(STEP)) dut (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(awprot),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
    .bready(bready), .araddr(araddr), .arprot(arprot), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .rx_word(rx_word), .rx_valid(rx_valid),
    .normal_word(normal_word), .normal_valid(normal_valid),
    .disp_label_oct(disp_label_oct), .disp_sdi(disp_sdi),
    .disp_data(disp_data), .disp_ssm(disp_ssm));
  rx_word_source src (.aclk(aclk), .aresetn(aresetn), .slow(slow),
    .rx_word(rx_word), .rx_valid(rx_valid));

  always #2.5 aclk = ~aclk;

  // Watchdog and ordinary reception monitor
  always @(posedge aclk) begin
    cyc++;
    if (normal_valid === 1'b1) last_norm <= normal_word;
    if (normal_valid === 1'b1) n_norm <= n_norm + 1;
    if (cyc == 60000) begin
      err_count++;
      $display("Error at %0t: run did not finish", $time);
      close_out();
    end
  end

  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : close_out

  // ==========================================================
  // Register bus master
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    forever begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    d = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // ==========================================================
  // Expectation helpers
  function automatic logic keep(input logic [31:0] w);
    return (!m_lc || w[7:0] == m_lab) && (!m_sc || w[9:8] == m_pat[1:0]) &&
      (!m_dc || ((w[31:8] ^ m_pat) & m_care) == 24'h0);
  endfunction : keep

  // Half the words are steered to the wanted label and pattern
  task automatic feed(input int n);
    logic [31:0] w;
    for (int i = 0; i < n; i++) begin
      w = $urandom;
      if (w[31]) w = {m_pat ^ (w[31:8] & ~m_care), m_lab};
      src.q.push_back(w);
      if (keep(w)) exp_q.push_back(w);
    end
  endtask : feed

  task automatic drain();
    while (src.q.size() != 0) @(posedge aclk);
    repeat (4) @(posedge aclk);
  endtask : drain

  task automatic chk_status(input int c, input logic f, input logic arm);
    logic [31:0] v;
    rd(OFF_STATUS, v);
    check({21'h0, v[10:0]}, {21'h0, f, arm, 9'(c)});
  endtask : chk_status

  task automatic view(input int i);
    logic [31:0] v;
    logic [31:0] e;
    wr(OFF_VIEW_INDEX, 32'(i));
    rd(OFF_VIEW_WORD, v);
    e = exp_q[i];
    check(v, e);
    check({20'h0, disp_label_oct},
          {22'h0, e[7:6], 1'b0, e[5:3], 1'b0, e[2:0]});
    check({4'h0, disp_ssm, disp_sdi, disp_data},
          {4'h0, e[30:29], e[9:8], 5'h0, e[28:10]});
  endtask : view

  task automatic trap_off();
    wr(OFF_CTRL, 32'h0);
    exp_q.delete();
  endtask : trap_off

  // ==========================================================
  // Main sequence
  initial begin
    int          n0, d2;
    logic [31:0] v, a, w, t;
    logic [23:0] masks[4];
    void'($urandom(44849));
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    rd(OFF_CARE, v);
    check(v, {8'h0, CARE_RESET});
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    rd(8'h3c, v);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    // Status is read-only, so a write there must be refused
    wr(OFF_STATUS, 32'h0);
    check({30'h0, resp}, {30'h0, RESP_SLVERR});
    // General trap with every parameter don't care
    {m_lc, m_sc, m_dc} = 3'b000;
    n0 = n_norm;
    wr(OFF_CTRL, 32'h1);
    check({30'h0, resp}, {30'h0, RESP_OKAY});
    feed(300);
    drain();
    chk_status(GENERAL_DEPTH, 1, 0);
    check(32'(n_norm), 32'(n0));
    view(0);
    view(1);
    view(GENERAL_DEPTH - 1);
    // Auto stepping follows the last scroll direction
    wr(OFF_SCROLL, 32'h2);
    wr(OFF_CTRL, 32'h9);
    rd(OFF_VIEW_INDEX, a);
    repeat (10 * STEP) @(posedge aclk);
    rd(OFF_VIEW_INDEX, v);
    d2 = (int'(a[8:0]) - int'(v[8:0]) + GENERAL_DEPTH) % GENERAL_DEPTH;
    check(32'(d2 >= 9 && d2 <= 11), 32'h1);
    // Manual scroll up from the last entry wraps to the first
    wr(OFF_CTRL, 32'h1);
    wr(OFF_VIEW_INDEX, 32'(GENERAL_DEPTH - 1));
    wr(OFF_SCROLL, 32'h1);
    rd(OFF_VIEW_INDEX, v);
    check(v, 32'h0);
    trap_off();
    chk_status(0, 0, 0);
    wr(OFF_VIEW_INDEX, 32'h0);
    rd(OFF_VIEW_WORD, v);
    check(v, 32'h0);
    w = $urandom;
    src.q.push_back(w);
    drain();
    check(last_norm, w);
    // Label filter with SDI
    {m_lc, m_sc, m_dc} = 3'b110;
    m_lab = 8'($urandom);
    m_pat = 24'($urandom);
    m_care = 24'h3;
    wr(OFF_LABEL, {22'h0, m_pat[1:0], m_lab});
    wr(OFF_CTRL, 32'h24);
    feed(80);
    drain();
    chk_status(exp_q.size(), 0, 0);
    view(exp_q.size() - 1);
    trap_off();
    // Data match under each care mask
    masks = '{24'h7fffff, CARE_RESET, 24'h600003, 24'($urandom)};
    {m_lc, m_sc, m_dc} = 3'b001;
    foreach (masks[k]) begin
      m_pat = 24'($urandom);
      m_care = masks[k];
      wr(OFF_PATTERN, {8'h0, m_pat});
      wr(OFF_CARE, {8'h0, m_care});
      wr(OFF_CTRL, 32'h41);
      feed(60);
      drain();
      chk_status(exp_q.size(), 0, 0);
      view(0);
      trap_off();
    end
    // Data-only capture, read back while capture runs on a slow link
    {m_lc, m_sc, m_dc} = 3'b100;
    m_lab = 8'($urandom);
    wr(OFF_LABEL, {24'h0, m_lab});
    wr(OFF_CTRL, 32'h3);
    slow = 1'b1;
    // Enough words that the kept half surely overfills the memory
    feed(1200);
    wr(OFF_VIEW_INDEX, 32'h0);
    // Entry 0 only exists once the first matching word has landed
    do begin
      rd(OFF_STATUS, v);
    end while (v[8:0] == 9'h0);
    while (src.q.size() > 200) begin
      rd(OFF_VIEW_WORD, v);
      check(v, exp_q[0]);
    end
    drain();
    slow = 1'b0;
    chk_status(DATA_ONLY_DEPTH, 1, 0);
    view(DATA_ONLY_DEPTH - 1);
    trap_off();
    // Trigger: the matching word starts capture, parity not compared
    t = $urandom;
    w = $urandom;
    wr(OFF_CARE, 32'h7fffff);
    wr(OFF_TRIG, {24'h0, t[7:0]});
    wr(OFF_TRIG_DATA, {8'h0, w[23:0]});
    wr(OFF_CTRL, 32'h81);
    chk_status(0, 0, 1);
    src.q.push_back({w[23:0] ^ 24'h1, t[7:0]});
    src.q.push_back({~w[23], w[22:0], t[7:0]});
    exp_q.push_back($urandom);
    exp_q.push_back($urandom);
    src.q.push_back(exp_q[0]);
    src.q.push_back(exp_q[1]);
    drain();
    chk_status(2, 0, 0);
    view(0);
    view(1);
    close_out();
  end
endmodule : serial_word_trap_filter_tb
